// ---- verilog/amis_pkg.sv ----
// Constants and types for the converter mode and input setup block
package amis_pkg;
  // ====================================================================
  // Register offsets
  localparam logic [7:0]  REG_RESET_OFS    = 8'h00;
  localparam logic [7:0]  REG_POWER_OFS    = 8'h0f;
  localparam logic [7:0]  REG_MODE_OFS     = 8'h31;
  localparam logic [7:0]  REG_SEL_A_OFS    = 8'h3a;
  localparam logic [7:0]  REG_SEL_B_OFS    = 8'h3b;
  localparam logic [7:0]  REG_PHASE_OFS    = 8'h42;
  // ====================================================================
  // Command values
  localparam logic [15:0] SOFT_RESET_VAL   = 16'h0001;
  localparam logic [15:0] POWER_ACTIVE_VAL = 16'h0000;
  localparam logic [15:0] POWER_DOWN_VAL   = 16'h0200;
  localparam logic [15:0] MODE_SINGLE_VAL  = 16'h0001;
  localparam logic [15:0] MODE_DUAL_VAL    = 16'h0102;
  localparam logic [15:0] MODE_QUAD_VAL    = 16'h0204;
  // ====================================================================
  // Reset values
  localparam logic [15:0] POWER_RST        = 16'h0000;
  localparam logic [15:0] MODE_RST         = 16'h0001;
  localparam logic [15:0] SEL_RST          = 16'h0202;
  localparam logic [15:0] PHASE_RST        = 16'h0000;
  // ====================================================================
  // One-hot input codes
  localparam logic [7:0]  IN_ONE_CODE      = 8'h02;
  localparam logic [7:0]  IN_TWO_CODE      = 8'h04;
  localparam logic [7:0]  IN_THREE_CODE    = 8'h08;
  localparam logic [7:0]  IN_FOUR_CODE     = 8'h10;
  localparam int          SPI_CMD_BITS     = 24;

  typedef enum logic [1:0] {
    AMIS_SINGLE = 2'b00,
    AMIS_DUAL   = 2'b01,
    AMIS_QUAD   = 2'b10,
    AMIS_BAD    = 2'b11
  } amis_mode_t;

  typedef struct packed {
    logic [7:0]  addr;
    logic [15:0] data;
  } amis_cmd_t;

  // Per converter channel route: one-hot over four analog inputs
  typedef struct packed {
    logic [3:0] ch4;
    logic [3:0] ch3;
    logic [3:0] ch2;
    logic [3:0] ch1;
  } amis_route_t;
endpackage

// ---- verilog/amis_top.sv ----
// Mode, clock divider, power-down and input routing control
`timescale 1ns/1ps
`default_nettype none
module amis_top
  import amis_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Device pins
  input  wire logic        active_low_reset_pin_i,
  input  wire logic        power_down_pin_i,
  // Serial control port (mode 0, msb first, read on 0x80 address bit)
  input  wire logic        spi_csn_i,
  input  wire logic        spi_sclk_i,
  input  wire logic        spi_mosi_i,
  output logic             spi_miso_o,
  // Converter controls
  output logic             powered_down_o,
  output amis_mode_t       mode_o,
  output logic [2:0]       clk_div_o,
  output logic             sample_en_o,
  output amis_route_t      route_o,
  output logic [15:0]      bit_clock_phase_o
);
  // ====================================================================
  // Pin synchronisers: three stages, change accepted when 2 and 3 agree
  logic [2:0] rstn_sync, pd_sync, csn_sync, sclk_sync, mosi_sync;
  logic       rstn_q, pd_q, csn_q, sclk_q, mosi_q, sclk_prev;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rstn_sync <= 3'b111;
      pd_sync   <= 3'b000;
      csn_sync  <= 3'b111;
      sclk_sync <= 3'b000;
      mosi_sync <= 3'b000;
    end else begin
      rstn_sync <= {rstn_sync[1:0], active_low_reset_pin_i};
      pd_sync   <= {pd_sync[1:0], power_down_pin_i};
      csn_sync  <= {csn_sync[1:0], spi_csn_i};
      sclk_sync <= {sclk_sync[1:0], spi_sclk_i};
      mosi_sync <= {mosi_sync[1:0], spi_mosi_i};
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rstn_q    <= 1'b1;
      pd_q      <= 1'b0;
      csn_q     <= 1'b1;
      sclk_q    <= 1'b0;
      mosi_q    <= 1'b0;
      sclk_prev <= 1'b0;
    end else begin
      if (rstn_sync[2] == rstn_sync[1]) rstn_q <= rstn_sync[2];
      if (pd_sync[2] == pd_sync[1]) pd_q <= pd_sync[2];
      if (csn_sync[2] == csn_sync[1]) csn_q <= csn_sync[2];
      if (sclk_sync[2] == sclk_sync[1]) sclk_q <= sclk_sync[2];
      if (mosi_sync[2] == mosi_sync[1]) mosi_q <= mosi_sync[2];
      sclk_prev <= sclk_q;
    end
  end
  // ====================================================================
  // Serial command shifter
  logic        sclk_rise, sclk_fall;
  logic [4:0]  bit_cnt_reg;
  amis_cmd_t   cmd_reg;
  logic        wr_stb;
  logic [15:0] rd_shift_reg;
  logic [15:0] rd_data;
  assign sclk_rise = sclk_q & ~sclk_prev & ~csn_q;
  assign sclk_fall = ~sclk_q & sclk_prev & ~csn_q;
  logic        last_bit_reg;
  // Write fires the cycle after the last bit lands, so the whole word is in
  assign wr_stb = last_bit_reg & ~cmd_reg.addr[7];
  always_ff @(posedge clk_i) begin
    if (rst_i || csn_q) begin
      bit_cnt_reg <= 5'h00;
      cmd_reg     <= '0;
    end else if (sclk_rise && bit_cnt_reg != 5'(SPI_CMD_BITS)) begin
      bit_cnt_reg <= bit_cnt_reg + 5'h01;
      cmd_reg     <= {cmd_reg[22:0], mosi_q};
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i || csn_q) begin
      last_bit_reg <= 1'b0;
    end else begin
      last_bit_reg <= sclk_rise & (bit_cnt_reg == 5'(SPI_CMD_BITS - 1));
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i || csn_q) begin
      rd_shift_reg <= 16'h0000;
    end else if (sclk_fall && bit_cnt_reg == 5'h08) begin
      rd_shift_reg <= cmd_reg[7] ? rd_data : 16'h0000;
    end else if (sclk_fall && bit_cnt_reg > 5'h08) begin
      rd_shift_reg <= {rd_shift_reg[14:0], 1'b0};
    end
  end
  // Read-back drives miso from a flip-flop; address bit 7 requests reads
  always_ff @(posedge clk_i) begin
    if (rst_i) spi_miso_o <= 1'b0;
    else spi_miso_o <= rd_shift_reg[15];
  end
  // ====================================================================
  // Register file
  logic [15:0] power_control_reg, mode_and_clock_divider_reg;
  logic [15:0] input_select_first_reg, input_select_second_reg;
  logic [15:0] output_bit_clock_phase_reg;
  logic        soft_reset, dev_reset;
  logic [7:0]  wr_addr;
  assign wr_addr    = {1'b0, cmd_reg.addr[6:0]};
  assign soft_reset = wr_stb & (wr_addr == REG_RESET_OFS)
                      & (cmd_reg.data == SOFT_RESET_VAL);
  assign dev_reset  = rst_i | ~rstn_q;
  always_ff @(posedge clk_i) begin
    if (dev_reset || soft_reset) begin
      power_control_reg          <= POWER_RST;
      mode_and_clock_divider_reg <= MODE_RST;
      input_select_first_reg     <= SEL_RST;
      input_select_second_reg    <= SEL_RST;
      output_bit_clock_phase_reg <= PHASE_RST;
    end else if (wr_stb) begin
      case (wr_addr)
        REG_POWER_OFS: power_control_reg          <= cmd_reg.data;
        REG_MODE_OFS:  mode_and_clock_divider_reg <= cmd_reg.data;
        REG_SEL_A_OFS: input_select_first_reg     <= cmd_reg.data;
        REG_SEL_B_OFS: input_select_second_reg    <= cmd_reg.data;
        REG_PHASE_OFS: output_bit_clock_phase_reg <= cmd_reg.data;
        default:       ;
      endcase
    end
  end
  always_comb begin
    // Address still sits in the low byte when read data is loaded
    case ({1'b0, cmd_reg[6:0]})
      REG_POWER_OFS: rd_data = power_control_reg;
      REG_MODE_OFS:  rd_data = mode_and_clock_divider_reg;
      REG_SEL_A_OFS: rd_data = input_select_first_reg;
      REG_SEL_B_OFS: rd_data = input_select_second_reg;
      REG_PHASE_OFS: rd_data = output_bit_clock_phase_reg;
      default:       rd_data = 16'h0000;
    endcase
  end
  // ====================================================================
  // Power-down: pin high or register value forces it
  assign powered_down_o = pd_q | (power_control_reg == POWER_DOWN_VAL);
  assign bit_clock_phase_o = output_bit_clock_phase_reg;
  // ====================================================================
  // Mode decode; the mode is latched only while powered down, since the
  // internal synchronisation cannot follow a change while sampling
  amis_mode_t mode_dec;
  always_comb begin
    case (mode_and_clock_divider_reg)
      MODE_SINGLE_VAL: mode_dec = AMIS_SINGLE;
      MODE_DUAL_VAL:   mode_dec = AMIS_DUAL;
      MODE_QUAD_VAL:   mode_dec = AMIS_QUAD;
      default:         mode_dec = AMIS_BAD;
    endcase
  end
  always_ff @(posedge clk_i) begin
    if (dev_reset || soft_reset) begin
      mode_o    <= AMIS_SINGLE;
      clk_div_o <= 3'h1;
    end else if (powered_down_o) begin
      mode_o    <= mode_dec;
      clk_div_o <= mode_and_clock_divider_reg[2:0];
    end
  end
  // ====================================================================
  // Sample enable divider; every step counts rising clock edges only
  // and needs no clock-format setting
  logic [2:0] div_cnt_reg;
  always_ff @(posedge clk_i) begin
    if (dev_reset || soft_reset || powered_down_o) begin
      div_cnt_reg <= 3'h0;
      sample_en_o <= 1'b0;
    end else if (div_cnt_reg + 3'h1 >= clk_div_o) begin
      div_cnt_reg <= 3'h0;
      sample_en_o <= 1'b1;
    end else begin
      div_cnt_reg <= div_cnt_reg + 3'h1;
      sample_en_o <= 1'b0;
    end
  end
  // ====================================================================
  // Routing: applied at once, no power-down needed
  always_ff @(posedge clk_i) begin
    if (dev_reset || soft_reset) begin
      route_o <= '0;
    end else begin
      case (mode_o)
        AMIS_SINGLE: begin
          route_o.ch1 <= input_select_first_reg[4:1];
          route_o.ch2 <= 4'h0;
          route_o.ch3 <= 4'h0;
          route_o.ch4 <= 4'h0;
        end
        AMIS_DUAL: begin
          route_o.ch1 <= input_select_first_reg[4:1];
          route_o.ch2 <= input_select_second_reg[4:1];
          route_o.ch3 <= 4'h0;
          route_o.ch4 <= 4'h0;
        end
        AMIS_QUAD: begin
          route_o.ch1 <= input_select_first_reg[12:9];
          route_o.ch2 <= input_select_first_reg[4:1];
          route_o.ch3 <= input_select_second_reg[12:9];
          route_o.ch4 <= input_select_second_reg[4:1];
        end
        default: route_o <= '0;
      endcase
    end
  end
endmodule
`default_nettype wire

// ---- tb/amis_chk.sv ----
// Assertion checker for the mode and input setup block
`timescale 1ns/1ps
`default_nettype none
module amis_chk
  import amis_pkg::*;
(
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        power_down_pin_i,
  input wire logic        powered_down_o,
  input wire amis_mode_t  mode_o,
  input wire logic [2:0]  clk_div_o,
  input wire logic        sample_en_o,
  input wire amis_route_t route_o
);
  // ==========
  // Sequences
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_gap3;
    !sample_en_o [*3];
  endsequence
  sequence s_active3;
    !powered_down_o [*3];
  endsequence
  // ==========
  // Properties
  a_single_div: assert property (mode_o == AMIS_SINGLE |-> clk_div_o == 3'h1)
    else $error("single mode divider wrong");
  a_dual_div: assert property (mode_o == AMIS_DUAL |-> clk_div_o == 3'h2)
    else $error("dual mode divider wrong");
  a_quad_div: assert property (mode_o == AMIS_QUAD |-> clk_div_o == 3'h4)
    else $error("quad mode divider wrong");
  a_div2_gap: assert property (sample_en_o && clk_div_o == 3'h2 |=> !sample_en_o)
    else $error("divide by two pulse too close");
  a_div4_gap: assert property (sample_en_o && clk_div_o == 3'h4 |=> s_gap3)
    else $error("divide by four pulse too close");
  a_div1_run: assert property (s_active3 ##0 clk_div_o == 3'h1 |-> sample_en_o)
    else $error("divide by one pulse missing");
  a_pin_down: assert property ($rose(power_down_pin_i) |-> ##[0:6] powered_down_o)
    else $error("pin did not power down");
  a_down_quiet: assert property (powered_down_o [*2] |-> !sample_en_o)
    else $error("sampling while powered down");
  a_mode_hold: assert property (!powered_down_o [*2] |-> $stable(mode_o))
    else $error("mode changed while active");
  a_route_hot: assert property ($onehot0(route_o.ch1) && $onehot0(route_o.ch2))
    else $error("route not one hot");
endmodule
bind amis_top amis_chk u_chk (
  .clk_i            (clk_i),
  .rst_i            (rst_i),
  .power_down_pin_i (power_down_pin_i),
  .powered_down_o   (powered_down_o),
  .mode_o           (mode_o),
  .clk_div_o        (clk_div_o),
  .sample_en_o      (sample_en_o),
  .route_o          (route_o)
);
`default_nettype wire

// ---- tb/amis_host.sv ----
// Host controller model acting as serial port master
`timescale 1ns/1ps
`default_nettype none
module amis_host (
  // Clock
  input  wire logic clk_i,
  // Serial port
  output logic      csn_o,
  output logic      sclk_o,
  output logic      mosi_o,
  input  wire logic miso_i
);
  // Slow half period keeps clear of the input synchronisers
  localparam int HALF = 8;
  initial begin
    csn_o = 1'b1;
    sclk_o = 1'b0;
    mosi_o = 1'b0;
  end
  // Whole frame before the next step
  task automatic xfer(input logic [7:0] a, input logic [15:0] d, output logic [15:0] q);
    logic [23:0] f;
    f = {a, d};
    q = 16'h0000;
    @(negedge clk_i);
    csn_o = 1'b0;
    for (int i = 23; i >= 0; i--) begin
      mosi_o = f[i];
      repeat (HALF) @(negedge clk_i);
      sclk_o = 1'b1;
      q = {q[14:0], miso_i};
      repeat (HALF) @(negedge clk_i);
      sclk_o = 1'b0;
    end
    repeat (HALF) @(negedge clk_i);
    csn_o = 1'b1;
    mosi_o = ~mosi_o;
    repeat (3 * HALF) @(negedge clk_i);
  endtask
endmodule
`default_nettype wire

// ---- tb/tb_top.sv ----
// Testbench for the mode and input setup block
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import amis_pkg::*;
;
  logic clk_i, rst_i, rstn_pin, pd_pin, csn, sclk, mosi, miso, pd_o, smp;
  logic [2:0]  div;
  logic [15:0] phase, q;
  amis_mode_t  mode;
  amis_route_t route;
  int          bad_count = 0;
  int          total_checks = 0;
  amis_top dut (.clk_i(clk_i), .rst_i(rst_i), .active_low_reset_pin_i(rstn_pin),
    .power_down_pin_i(pd_pin), .spi_csn_i(csn), .spi_sclk_i(sclk), .spi_mosi_i(mosi),
    .spi_miso_o(miso), .powered_down_o(pd_o), .mode_o(mode), .clk_div_o(div),
    .sample_en_o(smp), .route_o(route), .bit_clock_phase_o(phase));
  amis_host u_host (.clk_i(clk_i), .csn_o(csn), .sclk_o(sclk), .mosi_o(mosi), .miso_i(miso));
  // ==========
  // Helpers
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    u_host.xfer(a, d, q);
  endtask
  task automatic pin(input logic v);
    pd_pin = v;
    repeat (8) @(negedge clk_i);
  endtask
  task automatic finish_test;
    if (bad_count == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // ==========
  // Scenarios
  task automatic t_start;
    chk({10'h0, mode, pd_o, div}, 16'h0001);
    wr(REG_POWER_OFS, POWER_DOWN_VAL);
    chk({15'h0, pd_o}, 16'h0001);
    wr(REG_PHASE_OFS, 16'h00a5);
    chk(phase, 16'h00a5);
    wr(REG_MODE_OFS, MODE_DUAL_VAL);
    chk({11'h0, mode, div}, 16'h000a);
    u_host.xfer(8'hb1, 16'h0000, q);
    chk(q, 16'h0102);
    u_host.xfer(8'hd0, 16'h0000, q);
    chk(q, 16'h0000);
    wr(REG_POWER_OFS, POWER_ACTIVE_VAL);
    chk({15'h0, pd_o}, 16'h0000);
    wr(REG_SEL_A_OFS, 16'h0202);
    wr(REG_SEL_B_OFS, 16'h0808);
    chk({8'h0, route[7:0]}, 16'h0041);
  endtask
  task automatic t_quad;
    logic [15:0] n;
    wr(REG_MODE_OFS, MODE_QUAD_VAL);
    chk({11'h0, mode, div}, 16'h000a);
    pin(1'b1);
    wr(REG_MODE_OFS, MODE_QUAD_VAL);
    chk({11'h0, mode, div}, 16'h0014);
    pin(1'b0);
    chk({15'h0, pd_o}, 16'h0000);
    n = 16'h0000;
    repeat (16) begin
      @(negedge clk_i);
      n = n + 16'(smp);
    end
    chk(n, 16'h0004);
    wr(REG_SEL_A_OFS, 16'h1008);
    wr(REG_SEL_B_OFS, 16'h0402);
    chk(route, 16'h1248);
    wr(REG_SEL_A_OFS, 16'h0204);
    chk(route, 16'h1221);
  endtask
  task automatic t_single;
    pin(1'b1);
    wr(REG_MODE_OFS, MODE_SINGLE_VAL);
    chk({11'h0, mode, div}, 16'h0001);
    pin(1'b0);
    wr(REG_SEL_A_OFS, 16'h1010);
    wr(REG_SEL_B_OFS, 16'h1010);
    chk({12'h0, route.ch1}, 16'h0008);
  endtask
  task automatic t_resets;
    pin(1'b1);
    wr(REG_MODE_OFS, 16'h0007);
    chk({11'h0, mode, div}, 16'h001f);
    wr(REG_RESET_OFS, SOFT_RESET_VAL);
    chk(phase, 16'h0000);
    chk({11'h0, mode, div}, 16'h0001);
    wr(REG_PHASE_OFS, 16'h005a);
    chk(phase, 16'h005a);
    rstn_pin = 1'b0;
    repeat (8) @(negedge clk_i);
    rstn_pin = 1'b1;
    repeat (8) @(negedge clk_i);
    chk(phase, 16'h0000);
    pin(1'b0);
  endtask
  // ==========
  // Run
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  initial begin
    rst_i = 1'b1;
    rstn_pin = 1'b1;
    pd_pin = 1'b0;
    repeat (3) @(negedge clk_i);
    rst_i = 1'b0;
    repeat (6) @(negedge clk_i);
    t_start();
    t_quad();
    t_single();
    t_resets();
    finish_test();
  end
  // Hang guard well past the expected run
  initial begin
    repeat (60000) @(posedge clk_i);
    bad_count++;
    finish_test();
  end
endmodule
`default_nettype wire
